// [verilog/ppi_pkg.sv]
// Constants, register map and types for the parallel printer port block
package ppi_pkg;
   localparam int ADDR_W = 8;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_DATA = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_INT_STAT = 8'h0C;
   localparam logic [7:0] OFF_INT_MASK = 8'h10;
   localparam logic [7:0] OFF_TIMING = 8'h14;
   // Control register fields
   localparam int CTRL_W = 4;
   localparam int CTRL_SEL = 0;
   localparam int CTRL_INIT = 1;
   localparam int CTRL_AFD = 2;
   localparam int CTRL_DIR_IN = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;
   // Status register fields
   localparam int ST_SELECTED = 0;
   localparam int ST_PAPER = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_ACK_N = 3;
   localparam int ST_ERR_N = 4;
   localparam int ST_XFER = 5;
   localparam int ST_BYPASS = 6;
   localparam int ST_TEST = 7;
   localparam int ST_MULT_LSB = 8;
   localparam int ST_REF_LSB = 12;
   localparam int ST_OD_LSB = 16;
   // Interrupt status and mask fields
   localparam int IRQ_W = 5;
   localparam int IRQ_ACK = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_ERR = 2;
   localparam int IRQ_PAPER = 3;
   localparam int IRQ_READY = 4;
   localparam logic [4:0] MASK_RST = 5'h00;
   // Clocking figures reported to software
   localparam logic [3:0] REF_MHZ = 4'h6;
   localparam logic [3:0] PLL_MULT = 4'h8;
   // Timing
   localparam int CLK_NS = 100;
   localparam int T_SETUP_NS = 500;
   localparam int T_STROBE_NS = 500;
   localparam int T_HOLD_NS = 500;
   localparam int T_POR_NS = 1600;
   localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] STROBE_CYC = 8'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] POR_CYC = 8'((T_POR_NS + CLK_NS - 1) / CLK_NS);
   // Synchroniser vector layout
   localparam int SYNC_W = 21;
   localparam int SY_SEL = 0;
   localparam int SY_PAPER = 1;
   localparam int SY_BUSY = 2;
   localparam int SY_ACK_N = 3;
   localparam int SY_ERR_N = 4;
   localparam int SY_DATA_LSB = 5;
   localparam int SY_OD_LSB = 13;
   localparam int SY_BYPASS_N = 17;
   localparam int SY_TEST_N = 18;
   localparam int SY_SYSRST = 19;
   localparam int SY_OSC = 20;
   typedef enum logic [2:0] {X_IDLE, X_SETUP, X_STROBE, X_HOLD, X_WAIT} ppi_xfer_t;
endpackage

// [verilog/ppi_sync.sv]
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module ppi_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pins in, synchronised levels out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

// [verilog/ppi_port.sv]
// Parallel printer port with APB registers, strap and reset handling
//
// How it works
// - Reference timing from 6 MHz oscillator pins.
// - PLL multiplies reference by eight to 48 MHz.
// - Bypass strap low: external 48 MHz used.
// - Test strap low enters internal test mode.
// - System reset high initialises all state.
// - Reset pin tied low: internal power-on reset.
// - Eight-bit two-way data bus, bit 7 MSB.
// - Printer captures data while strobe is low.
// - Select-in pulled low selects the printer.
// - Initialize pulled low starts printer initialisation.
// - Auto-feed pulled low selects continuous feed.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module ppi_port (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq,
   // Oscillator, straps and system reset pins
   input wire logic osc_in,
   output logic osc_out,
   input wire logic pll_bypass_strap_n,
   input wire logic internal_test_strap_n,
   input wire logic sys_reset_in,
   // Printer status inputs
   input wire logic printer_selected_in,
   input wire logic paper_out_in,
   input wire logic busy_in,
   input wire logic byte_ack_in_n,
   input wire logic printer_error_in_n,
   // Printer data bus, bit 7 is pdata_7
   input wire logic [7:0] pdata_i,
   output logic [7:0] pdata_o,
   output logic pdata_oe,
   // Open-drain controls: select-in, init, auto-feed, strobe
   input wire logic printer_select_out_n_i,
   output logic printer_select_out_n_o,
   output logic printer_select_out_n_oe,
   input wire logic printer_init_out_n_i,
   output logic printer_init_out_n_o,
   output logic printer_init_out_n_oe,
   input wire logic auto_feed_out_n_i,
   output logic auto_feed_out_n_o,
   output logic auto_feed_out_n_oe,
   input wire logic data_strobe_out_n_i,
   output logic data_strobe_out_n_o,
   output logic data_strobe_out_n_oe
);
   logic [ppi_pkg::SYNC_W-1:0] pins_raw;
   logic [ppi_pkg::SYNC_W-1:0] pins_s;
   logic [7:0] por_cnt_r;
   logic por_done_r;
   logic rst_int_r;
   logic straps_taken_r;
   logic bypass_r;
   logic test_mode_r;
   logic [3:0] ctrl_r;
   logic [7:0] data_r;
   logic go_r;
   logic [ppi_pkg::IRQ_W-1:0] int_stat_r;
   logic [ppi_pkg::IRQ_W-1:0] int_mask_r;
   logic [ppi_pkg::IRQ_W-1:0] int_set;
   logic [7:0] t_setup_r;
   logic [7:0] t_strobe_r;
   logic [7:0] t_hold_r;
   ppi_pkg::ppi_xfer_t xfer_r;
   ppi_pkg::ppi_xfer_t xfer_nxt;
   logic [7:0] cnt_r;
   logic [4:0] stat_prev_r;
   logic [31:0] status_word;
   logic [31:0] rd_mux;
   logic rd_err;
   logic acc;
   logic wr_ctrl;
   logic wr_data;
   logic wr_mask;
   logic wr_timing;
   logic rd_int;
   logic data_refused;
   logic busy_s;
   logic ack_fall;
   logic done_ev;
   logic od_low_r;

   // Timed phase ends once the counter has covered the programmed cycles
   function automatic logic ppi_tdone(input logic [7:0] cnt, input logic [7:0] lim);
      ppi_tdone = ({1'b0, cnt} + 9'h001) >= {1'b0, lim};
   endfunction

   assign pins_raw = {osc_in, sys_reset_in, internal_test_strap_n, pll_bypass_strap_n,
                      data_strobe_out_n_i, auto_feed_out_n_i, printer_init_out_n_i,
                      printer_select_out_n_i, pdata_i, printer_error_in_n, byte_ack_in_n,
                      busy_in, paper_out_in, printer_selected_in};

   ppi_sync #(.W(ppi_pkg::SYNC_W)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   assign busy_s = pins_s[ppi_pkg::SY_BUSY];

   // Power-on reset timer covers a reset pin that is tied low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_cnt_r <= 8'h00;
         por_done_r <= 1'b0;
      end else if (!por_done_r) begin
         por_cnt_r <= por_cnt_r + 8'h01;
         por_done_r <= ppi_tdone(por_cnt_r, ppi_pkg::POR_CYC);
      end
   end

   // Internal reset: power-on window or the synchronised system reset pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_int_r <= 1'b1;
      end else begin
         rst_int_r <= !por_done_r || pins_s[ppi_pkg::SY_SYSRST];
      end
   end

   // Straps are caught while the internal reset is active
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         straps_taken_r <= 1'b0;
         bypass_r <= 1'b0;
         test_mode_r <= 1'b0;
      end else if (rst_int_r) begin
         straps_taken_r <= 1'b1;
         bypass_r <= !pins_s[ppi_pkg::SY_BYPASS_N];
         test_mode_r <= !pins_s[ppi_pkg::SY_TEST_N];
      end
   end

   // Oscillator feedback inverter; parked low when an external clock is used
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_out <= 1'b0;
      end else begin
         osc_out <= !bypass_r && !pins_s[ppi_pkg::SY_OSC];
      end
   end

   // APB decode
   assign acc = psel && penable && pready;
   assign wr_ctrl = acc && pwrite && (paddr == ppi_pkg::OFF_CTRL);
   assign wr_data = acc && pwrite && (paddr == ppi_pkg::OFF_DATA) && !pslverr;
   assign wr_mask = acc && pwrite && (paddr == ppi_pkg::OFF_INT_MASK);
   assign wr_timing = acc && pwrite && (paddr == ppi_pkg::OFF_TIMING);
   assign rd_int = acc && !pwrite && (paddr == ppi_pkg::OFF_INT_STAT);
   assign data_refused = (xfer_r != ppi_pkg::X_IDLE) || go_r
                         || ctrl_r[ppi_pkg::CTRL_DIR_IN] || rst_int_r;

   assign status_word = {12'h000,
                         pins_s[ppi_pkg::SY_OD_LSB +: 4],
                         ppi_pkg::REF_MHZ,
                         ppi_pkg::PLL_MULT,
                         test_mode_r,
                         bypass_r,
                         (xfer_r != ppi_pkg::X_IDLE) || go_r,
                         pins_s[ppi_pkg::SY_ERR_N],
                         pins_s[ppi_pkg::SY_ACK_N],
                         busy_s,
                         pins_s[ppi_pkg::SY_PAPER],
                         pins_s[ppi_pkg::SY_SEL]};

   always_comb begin
      rd_mux = 32'h00000000;
      rd_err = 1'b0;
      unique case (paddr)
         ppi_pkg::OFF_CTRL: rd_mux = {28'h0000000, ctrl_r};
         ppi_pkg::OFF_DATA: begin
            rd_mux = ctrl_r[ppi_pkg::CTRL_DIR_IN]
                     ? {24'h000000, pins_s[ppi_pkg::SY_DATA_LSB +: 8]}
                     : {24'h000000, data_r};
            rd_err = pwrite && data_refused;
         end
         ppi_pkg::OFF_STATUS: rd_mux = status_word;
         ppi_pkg::OFF_INT_STAT: rd_mux = {27'h0000000, int_stat_r};
         ppi_pkg::OFF_INT_MASK: rd_mux = {27'h0000000, int_mask_r};
         ppi_pkg::OFF_TIMING: rd_mux = {8'h00, t_hold_r, t_strobe_r, t_setup_r};
         default: rd_err = 1'b1;
      endcase
   end

   // No wait states: answer is prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h00000000 : rd_mux;
         pslverr <= rd_err;
      end else begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end

   // Control register: select-in, init, auto-feed, data direction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= ppi_pkg::CTRL_RST;
      end else if (rst_int_r) begin
         ctrl_r <= ppi_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= pwdata[ppi_pkg::CTRL_W-1:0];
      end
   end

   // Byte to print and its start request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_r <= 8'h00;
         go_r <= 1'b0;
      end else if (rst_int_r) begin
         data_r <= 8'h00;
         go_r <= 1'b0;
      end else if (wr_data) begin
         data_r <= pwdata[7:0];
         go_r <= !test_mode_r;
      end else if (xfer_r == ppi_pkg::X_IDLE) begin
         go_r <= 1'b0;
      end
   end

   // Strobe timing register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t_setup_r <= ppi_pkg::SETUP_CYC;
         t_strobe_r <= ppi_pkg::STROBE_CYC;
         t_hold_r <= ppi_pkg::HOLD_CYC;
      end else if (rst_int_r) begin
         t_setup_r <= ppi_pkg::SETUP_CYC;
         t_strobe_r <= ppi_pkg::STROBE_CYC;
         t_hold_r <= ppi_pkg::HOLD_CYC;
      end else if (wr_timing) begin
         t_setup_r <= pwdata[7:0];
         t_strobe_r <= pwdata[15:8];
         t_hold_r <= pwdata[23:16];
      end
   end

   // Byte transfer sequencer
   always_comb begin
      xfer_nxt = xfer_r;
      unique case (xfer_r)
         ppi_pkg::X_IDLE: begin
            if (go_r) begin
               xfer_nxt = ppi_pkg::X_SETUP;
            end
         end
         ppi_pkg::X_SETUP: begin
            if (ppi_tdone(cnt_r, t_setup_r) && !busy_s) begin
               xfer_nxt = ppi_pkg::X_STROBE;
            end
         end
         ppi_pkg::X_STROBE: begin
            if (ppi_tdone(cnt_r, t_strobe_r)) begin
               xfer_nxt = ppi_pkg::X_HOLD;
            end
         end
         ppi_pkg::X_HOLD: begin
            if (ppi_tdone(cnt_r, t_hold_r)) begin
               xfer_nxt = ppi_pkg::X_WAIT;
            end
         end
         ppi_pkg::X_WAIT: begin
            if (ack_fall || !busy_s) begin
               xfer_nxt = ppi_pkg::X_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xfer_r <= ppi_pkg::X_IDLE;
         cnt_r <= 8'h00;
      end else if (rst_int_r) begin
         xfer_r <= ppi_pkg::X_IDLE;
         cnt_r <= 8'h00;
      end else begin
         xfer_r <= xfer_nxt;
         cnt_r <= (xfer_nxt != xfer_r) ? 8'h00 : cnt_r + 8'h01;
      end
   end

   assign done_ev = (xfer_r == ppi_pkg::X_WAIT) && (xfer_nxt == ppi_pkg::X_IDLE);

   // Edge detection on synchronised status levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_prev_r <= 5'h1F;
      end else begin
         stat_prev_r <= pins_s[ppi_pkg::SY_ERR_N:ppi_pkg::SY_SEL];
      end
   end

   assign ack_fall = stat_prev_r[ppi_pkg::SY_ACK_N] && !pins_s[ppi_pkg::SY_ACK_N];

   always_comb begin
      int_set = '0;
      int_set[ppi_pkg::IRQ_ACK] = ack_fall;
      int_set[ppi_pkg::IRQ_DONE] = done_ev;
      int_set[ppi_pkg::IRQ_ERR] = stat_prev_r[ppi_pkg::SY_ERR_N]
                                  && !pins_s[ppi_pkg::SY_ERR_N];
      int_set[ppi_pkg::IRQ_PAPER] = !stat_prev_r[ppi_pkg::SY_PAPER]
                                    && pins_s[ppi_pkg::SY_PAPER];
      int_set[ppi_pkg::IRQ_READY] = stat_prev_r[ppi_pkg::SY_BUSY] && !busy_s;
   end

   // Sticky interrupt status, cleared by read; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_r <= '0;
      end else if (rst_int_r) begin
         int_stat_r <= '0;
      end else begin
         int_stat_r <= (rd_int ? int_stat_r & ~prdata[ppi_pkg::IRQ_W-1:0] : int_stat_r) | int_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask_r <= ppi_pkg::MASK_RST;
      end else if (rst_int_r) begin
         int_mask_r <= ppi_pkg::MASK_RST;
      end else if (wr_mask) begin
         int_mask_r <= pwdata[ppi_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_stat_r & int_mask_r);
      end
   end

   // Data bus: driven from the byte register unless software turned it round
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pdata_o <= 8'h00;
         pdata_oe <= 1'b0;
      end else if (rst_int_r) begin
         pdata_o <= 8'h00;
         pdata_oe <= 1'b0;
      end else begin
         pdata_o <= data_r;
         pdata_oe <= !ctrl_r[ppi_pkg::CTRL_DIR_IN];
      end
   end

   // Open-drain controls only ever pull low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         od_low_r <= 1'b0;
         printer_select_out_n_oe <= 1'b0;
         printer_init_out_n_oe <= 1'b0;
         auto_feed_out_n_oe <= 1'b0;
         data_strobe_out_n_oe <= 1'b0;
      end else if (rst_int_r) begin
         od_low_r <= 1'b0;
         printer_select_out_n_oe <= 1'b0;
         printer_init_out_n_oe <= 1'b0;
         auto_feed_out_n_oe <= 1'b0;
         data_strobe_out_n_oe <= 1'b0;
      end else begin
         od_low_r <= 1'b0;
         printer_select_out_n_oe <= ctrl_r[ppi_pkg::CTRL_SEL];
         printer_init_out_n_oe <= ctrl_r[ppi_pkg::CTRL_INIT];
         auto_feed_out_n_oe <= ctrl_r[ppi_pkg::CTRL_AFD];
         data_strobe_out_n_oe <= (xfer_nxt == ppi_pkg::X_STROBE);
      end
   end

   assign printer_select_out_n_o = od_low_r;
   assign printer_init_out_n_o = od_low_r;
   assign auto_feed_out_n_o = od_low_r;
   assign data_strobe_out_n_o = od_low_r;

endmodule

// [verif/ppi_port_chk.sv]
// Assertion checker for the parallel printer port
`timescale 1ns/1ps
module ppi_port_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Printer side
   input wire logic busy_in,
   input wire logic [7:0] pdata_o,
   input wire logic pdata_oe,
   input wire logic printer_select_out_n_o,
   input wire logic printer_init_out_n_o,
   input wire logic auto_feed_out_n_o,
   input wire logic data_strobe_out_n_o,
   input wire logic data_strobe_out_n_oe
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   strobe_width_a: assert property (
      $rose(data_strobe_out_n_oe) |-> data_strobe_out_n_oe [*5] ##1 !data_strobe_out_n_oe)
      else $error("strobe width wrong");
   strobe_data_a: assert property (
      data_strobe_out_n_oe |-> pdata_oe && $stable(pdata_o))
      else $error("data moved under strobe");
   setup_stable_a: assert property (
      $rose(data_strobe_out_n_oe) |-> $past(pdata_oe, 4) && $past(pdata_o, 4) == pdata_o)
      else $error("data not set up before strobe");
   busy_gate_a: assert property (
      $rose(data_strobe_out_n_oe) |-> !$past(busy_in, 3))
      else $error("strobe while printer busy");
   hold_stable_a: assert property (
      $fell(data_strobe_out_n_oe) |-> (pdata_oe && $stable(pdata_o)) [*5])
      else $error("data not held after strobe");
   apb_ready_a: assert property (
      psel && !penable ##1 psel && penable |-> pready)
      else $error("no ready in first access cycle");
   ready_pulse_a: assert property (
      pready |-> psel && penable && $past(psel && !penable))
      else $error("ready outside first access cycle");
   slverr_qual_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   idle_read_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   od_low_a: assert property (
      !(printer_select_out_n_o | printer_init_out_n_o | auto_feed_out_n_o | data_strobe_out_n_o))
      else $error("open drain drives high");
endmodule

bind ppi_port ppi_port_chk u_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready,
   .pslverr, .busy_in, .pdata_o, .pdata_oe, .printer_select_out_n_o, .printer_init_out_n_o,
   .auto_feed_out_n_o, .data_strobe_out_n_o, .data_strobe_out_n_oe);

// [verif/ppi_printer_model.sv]
// Behavioural printer on the far side of the parallel port
`timescale 1ns/1ps
module ppi_printer_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pin levels from the port
   input wire logic strobe_n,
   input wire logic init_n,
   input wire logic [7:0] pdata,
   // Bench controls
   input wire logic hold_busy,
   input wire logic [4:0] ack_delay,
   input wire logic selected,
   input wire logic paper_out,
   input wire logic fault,
   // Status pins to the port
   output logic busy,
   output logic ack_n,
   output logic sel_pin,
   output logic paper_pin,
   output logic err_pin_n,
   // Observations
   output logic [7:0] got,
   output logic [7:0] bytes,
   output logic [7:0] inits
);
   logic busy_r;
   logic seen_r;
   logic init_q;
   logic [4:0] wait_r;
   assign busy = busy_r | hold_busy;
   assign sel_pin = selected;
   assign paper_pin = paper_out;
   assign err_pin_n = !fault;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r <= 1'b0;
         seen_r <= 1'b0;
         ack_n <= 1'b1;
         wait_r <= 5'h00;
         got <= 8'h00;
         bytes <= 8'h00;
      end else begin
         ack_n <= 1'b1;
         if (!strobe_n && !seen_r) begin
            got <= pdata;
            busy_r <= 1'b1;
            seen_r <= 1'b1;
         end else if (strobe_n && seen_r) begin
            if (wait_r == ack_delay) begin
               ack_n <= 1'b0;
               busy_r <= 1'b0;
               seen_r <= 1'b0;
               wait_r <= 5'h00;
               bytes <= bytes + 8'h01;
            end else begin
               wait_r <= wait_r + 5'h01;
            end
         end
      end
   end
   // Counts falling edges of the initialise line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_q <= 1'b1;
         inits <= 8'h00;
      end else begin
         init_q <= init_n;
         if (init_q && !init_n) begin
            inits <= inits + 8'h01;
         end
      end
   end
endmodule

// [verif/ppi_port_tb.sv]
// Self-checking bench for the parallel printer port
`timescale 1ns/1ps
module ppi_port_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, osc_in, osc_out;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic bypass_n, test_n, sys_reset_in, rerr, pdata_oe;
   logic sel_pin, paper_pin, busy_pin, ack_n, err_n, hold_busy, selected, paper_out, fault;
   logic [7:0] pdata_o, pdata_bus, got, bytes, inits;
   logic [3:0] od_oe, od_o, od_pin;
   logic [4:0] ack_delay;
   int errors, checked, cyc;
   assign od_pin = (od_o & od_oe) | ~od_oe;
   assign pdata_bus = pdata_oe ? pdata_o : ~pdata_o;
   ppi_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .osc_in(osc_in), .osc_out(osc_out),
      .pll_bypass_strap_n(bypass_n), .internal_test_strap_n(test_n),
      .sys_reset_in(sys_reset_in), .printer_selected_in(sel_pin), .paper_out_in(paper_pin),
      .busy_in(busy_pin), .byte_ack_in_n(ack_n), .printer_error_in_n(err_n),
      .pdata_i(pdata_bus), .pdata_o(pdata_o), .pdata_oe(pdata_oe),
      .printer_select_out_n_i(od_pin[0]), .printer_select_out_n_o(od_o[0]),
      .printer_select_out_n_oe(od_oe[0]), .printer_init_out_n_i(od_pin[1]),
      .printer_init_out_n_o(od_o[1]), .printer_init_out_n_oe(od_oe[1]),
      .auto_feed_out_n_i(od_pin[2]), .auto_feed_out_n_o(od_o[2]),
      .auto_feed_out_n_oe(od_oe[2]), .data_strobe_out_n_i(od_pin[3]),
      .data_strobe_out_n_o(od_o[3]), .data_strobe_out_n_oe(od_oe[3]));
   ppi_printer_model prn (.pclk(pclk), .presetn(presetn), .strobe_n(od_pin[3]),
      .init_n(od_pin[1]), .pdata(pdata_bus), .hold_busy(hold_busy), .ack_delay(ack_delay),
      .selected(selected), .paper_out(paper_out), .fault(fault), .busy(busy_pin),
      .ack_n(ack_n), .sel_pin(sel_pin), .paper_pin(paper_pin), .err_pin_n(err_n),
      .got(got), .bytes(bytes), .inits(inits));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) osc_in <= ~osc_in;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat & m, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk({31'h0, rerr}, {31'h0, e});
   endtask
   task automatic wait_bytes(input logic [7:0] n);
      int k;
      for (k = 0; k < 300 && bytes !== n; k++) @(posedge pclk);
      chk(32'(bytes), 32'(n));
   endtask
   task automatic do_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (25) @(posedge pclk);
   endtask
   task automatic t_regs;
      rd(ppi_pkg::OFF_CTRL, 32'hF, 32'h0);
      rd(ppi_pkg::OFF_INT_MASK, 32'h1F, 32'h0);
      rd(ppi_pkg::OFF_STATUS, 32'hFFC0, 32'h6800);
      rd(ppi_pkg::OFF_TIMING, 32'hFFFFFF, 32'h050505);
      wr(8'h20, 32'h0, 1'b1);
      $display("register test done");
   endtask
   task automatic t_controls;
      for (int i = 0; i < 4; i++) begin
         wr(ppi_pkg::OFF_CTRL, 32'(1 << i), 1'b0);
         repeat (3) @(posedge pclk);
         chk({28'h0, od_oe}, 32'(1 << i) & 32'h7);
      end
      rd(ppi_pkg::OFF_DATA, 32'hFF, 32'hFF);
      chk(32'(inits), 32'h1);
      wr(ppi_pkg::OFF_CTRL, 32'h0, 1'b0);
      $display("control test done");
   endtask
   task automatic t_byte;
      int k;
      wr(ppi_pkg::OFF_INT_MASK, 32'h2, 1'b0);
      wr(ppi_pkg::OFF_DATA, 32'hA5, 1'b0);
      wr(ppi_pkg::OFF_DATA, 32'h3C, 1'b1);
      wait_bytes(8'h01);
      chk(32'(got), 32'hA5);
      for (k = 0; k < 50 && irq !== 1'b1; k++) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      rd(ppi_pkg::OFF_INT_STAT, 32'h2, 32'h2);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      hold_busy <= 1'b1;
      ack_delay <= 5'h14;
      wr(ppi_pkg::OFF_DATA, 32'h81, 1'b0);
      k = 0;
      repeat (40) begin
         @(posedge pclk);
         if (od_oe[3] !== 1'b0) k++;
      end
      chk(32'(k), 32'h0);
      hold_busy <= 1'b0;
      wait_bytes(8'h02);
      chk(32'(got), 32'h81);
      ack_delay <= 5'h02;
      $display("byte test done");
   endtask
   task automatic t_status;
      wr(ppi_pkg::OFF_INT_MASK, 32'h8, 1'b0);
      rd(ppi_pkg::OFF_INT_STAT, 32'h2, 32'h2);
      fault <= 1'b1;
      selected <= 1'b1;
      repeat (6) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      paper_out <= 1'b1;
      repeat (6) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      rd(ppi_pkg::OFF_STATUS, 32'h1F, 32'h0B);
      rd(ppi_pkg::OFF_INT_STAT, 32'hC, 32'hC);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      fault <= 1'b0;
      selected <= 1'b0;
      paper_out <= 1'b0;
      repeat (6) @(posedge pclk);
      rd(ppi_pkg::OFF_STATUS, 32'h1F, 32'h18);
      $display("status test done");
   endtask
   task automatic t_straps;
      int k;
      logic a;
      bypass_n <= 1'b0;
      test_n <= 1'b0;
      do_reset();
      rd(ppi_pkg::OFF_STATUS, 32'hC0, 32'hC0);
      k = 0;
      repeat (10) begin
         @(posedge pclk);
         if (osc_out !== 1'b0) k++;
      end
      chk(32'(k), 32'h0);
      wr(ppi_pkg::OFF_DATA, 32'h5A, 1'b0);
      repeat (30) @(posedge pclk);
      chk(32'(pdata_bus), 32'h5A);
      chk(32'(bytes), 32'h0);
      bypass_n <= 1'b1;
      test_n <= 1'b1;
      do_reset();
      rd(ppi_pkg::OFF_STATUS, 32'hC0, 32'h0);
      @(posedge pclk);
      a = osc_out;
      @(posedge pclk);
      chk({31'h0, osc_out}, {31'h0, ~a});
      $display("strap test done");
   endtask
   task automatic t_sysreset;
      wr(ppi_pkg::OFF_CTRL, 32'h1, 1'b0);
      sys_reset_in <= 1'b1;
      repeat (6) @(posedge pclk);
      chk({28'h0, od_oe}, 32'h0);
      sys_reset_in <= 1'b0;
      repeat (25) @(posedge pclk);
      rd(ppi_pkg::OFF_CTRL, 32'hF, 32'h0);
      $display("system reset test done");
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, osc_in, sys_reset_in, hold_busy} = 7'h00;
      {selected, paper_out, fault} = 3'h0;
      {bypass_n, test_n} = 2'h3;
      paddr = 8'h00;
      pwdata = 32'h0;
      ack_delay = 5'h02;
      errors = 0;
      checked = 0;
      cyc = 0;
      do_reset();
      t_regs();
      t_controls();
      t_byte();
      t_status();
      t_sysreset();
      t_straps();
      report_and_stop();
   end
endmodule
